// file: src/usbcb_cfg.svh
`ifndef USBCB_CFG_SVH
`define USBCB_CFG_SVH

// Command byte 0 fields
`define USBCB_OP_WRITE 8'h10
`define USBCB_SEL_MASK 8'h0f
`define USBCB_BAD_MASK 8'he0
`define USBCB_SEL_SPI8 4'h0
`define USBCB_SEL_TWO_WIRE_STANDARD_MODE 4'h1
`define USBCB_SEL_I2C_FAST 4'h2
`define USBCB_SEL_SPI16 4'h4
`define USBCB_SEL_GPIO 4'h8

// Reply status flags
`define USBCB_ST_REQ_ERR 8'h80
`define USBCB_ST_BUS_ERR 8'h40
`define USBCB_ST_DONE 8'h20

// Packet layout
`define USBCB_B_IFACE 6'h00
`define USBCB_B_ADDR 6'h01
`define USBCB_B_LEN 6'h02
`define USBCB_B_REG 6'h03
`define USBCB_B_DATA 6'h04
`define USBCB_PKT_MAX 7'h40
`define USBCB_HDR_LEN 7'h04
`define USBCB_DATA_MAX 8'h3c
`define USBCB_REPLY_MAX 7'h3d
`define USBCB_GPIO_LEN 8'h01
`define USBCB_VENDOR_CLASS 8'hff

// Timing, rounded up to whole clock cycles
`define USBCB_CLK_NS 100
`define USBCB_STD_QTR_NS 2500
`define USBCB_FAST_QTR_NS 625
`define USBCB_SPI_HALF_NS 500
`define USBCB_CYC(ns) (((ns) + `USBCB_CLK_NS - 1) / `USBCB_CLK_NS)

`endif

// file: src/usbcb_pkg.sv
package usbcb_pkg;

  typedef enum logic [2:0] {
    ECMD_START = 3'h0,
    ECMD_WRITE = 3'h1,
    ECMD_READ = 3'h2,
    ECMD_STOP = 3'h3,
    ECMD_SPI = 3'h4
  } usbcb_ecmd_type;

  typedef enum logic [2:0] {
    E_IDLE = 3'h0,
    E_START = 3'h1,
    E_BIT = 3'h2,
    E_STOP = 3'h3,
    E_SPI = 3'h4
  } usbcb_estate_type;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_DECODE = 4'h1,
    S_START = 4'h2,
    S_ADDR = 4'h3,
    S_REG_HI = 4'h4,
    S_REG = 4'h5,
    S_RESTART = 4'h6,
    S_ADDR_RD = 4'h7,
    S_DATA = 4'h8,
    S_STOP = 4'h9,
    S_GPIO = 4'ha,
    S_REPLY = 4'hb
  } usbcb_state_type;

endpackage : usbcb_pkg

// file: src/usbcb_eng_if.sv
`timescale 1ns/1ps
interface usbcb_eng_if;
  import usbcb_pkg::*;
  logic go;
  usbcb_ecmd_type cmd;
  logic fast;
  logic last;
  logic [7:0] tx;
  logic done;
  logic nack;
  logic [7:0] rx;
  modport ctrl (output go, output cmd, output fast, output last, output tx, input done, input nack, input rx);
  modport eng (input go, input cmd, input fast, input last, input tx, output done, output nack, output rx);
endinterface : usbcb_eng_if

// file: src/usbcb_engine.sv
`timescale 1ns/1ps
`include "usbcb_cfg.svh"
module usbcb_engine
  import usbcb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  usbcb_eng_if.eng e,
  input wire logic scl_in,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_oe,
  output logic spi_sclk,
  output logic spi_mosi,
  input wire logic spi_miso
);

  typedef struct packed {
    usbcb_estate_type st;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [4:0] div;
    logic [8:0] sh;
    logic [7:0] rx;
    logic nack;
    logic done;
    logic scl_oe;
    logic sda_oe;
    logic sclk;
    logic mosi;
  } usbcb_eng_state_type;

  usbcb_eng_state_type q_ff, nxt_q;
  logic tick;
  logic [4:0] reload;

  // No clock stretching: targets must keep up with the chosen rate
  always_comb begin
    nxt_q = q_ff;
    nxt_q.done = 1'b0;
    tick = (q_ff.div == 5'h00);
    if (e.cmd == ECMD_SPI) begin
      reload = 5'(`USBCB_CYC(`USBCB_SPI_HALF_NS) - 1);
    end else if (e.fast) begin
      reload = 5'(`USBCB_CYC(`USBCB_FAST_QTR_NS) - 1);
    end else begin
      reload = 5'(`USBCB_CYC(`USBCB_STD_QTR_NS) - 1);
    end
    if (q_ff.st != E_IDLE) begin
      nxt_q.div = tick ? reload : q_ff.div - 5'h01;
      if (tick) begin
        nxt_q.ph = q_ff.ph + 2'h1;
      end
    end
    case (q_ff.st)
      E_IDLE: begin
        if (e.go) begin
          nxt_q.div = reload;
          nxt_q.ph = 2'h0;
          nxt_q.bitn = 4'h0;
          nxt_q.nack = 1'b0;
          case (e.cmd)
            ECMD_START: nxt_q.st = E_START;
            ECMD_STOP: nxt_q.st = E_STOP;
            ECMD_WRITE: begin
              nxt_q.sh = {e.tx, 1'b1};
              nxt_q.st = E_BIT;
            end
            ECMD_READ: begin
              // Ack every byte but the last
              nxt_q.sh = {8'hff, e.last};
              nxt_q.st = E_BIT;
            end
            default: begin
              nxt_q.sh = {e.tx, 1'b0};
              nxt_q.st = E_SPI;
            end
          endcase
        end
      end
      E_START: begin
        // Works both idle and as repeated start after a byte
        if (tick) begin
          case (q_ff.ph)
            2'h0: nxt_q.sda_oe = 1'b0;
            2'h1: nxt_q.scl_oe = 1'b0;
            2'h2: nxt_q.sda_oe = 1'b1;
            default: begin
              nxt_q.scl_oe = 1'b1;
              nxt_q.done = 1'b1;
              nxt_q.st = E_IDLE;
            end
          endcase
        end
      end
      E_BIT: begin
        if (tick) begin
          case (q_ff.ph)
            2'h0: nxt_q.sda_oe = !q_ff.sh[8];
            2'h1: nxt_q.scl_oe = 1'b0;
            2'h2: begin
              if (q_ff.bitn == 4'h8) begin
                nxt_q.nack = sda_in;
              end else begin
                nxt_q.rx = {q_ff.rx[6:0], sda_in};
              end
            end
            default: begin
              nxt_q.scl_oe = 1'b1;
              nxt_q.sh = {q_ff.sh[7:0], 1'b1};
              nxt_q.bitn = q_ff.bitn + 4'h1;
              if (q_ff.bitn == 4'h8) begin
                nxt_q.sda_oe = 1'b0;
                nxt_q.done = 1'b1;
                nxt_q.st = E_IDLE;
              end
            end
          endcase
        end
      end
      E_STOP: begin
        if (tick) begin
          case (q_ff.ph)
            2'h0: nxt_q.sda_oe = 1'b1;
            2'h1: nxt_q.scl_oe = 1'b0;
            default: begin
              nxt_q.sda_oe = 1'b0;
              nxt_q.done = 1'b1;
              nxt_q.st = E_IDLE;
            end
          endcase
        end
      end
      default: begin
        // Mode 0: set up on low, sample on rising edge
        if (tick) begin
          case (q_ff.ph)
            2'h0: nxt_q.mosi = q_ff.sh[8];
            2'h1: begin
              nxt_q.sclk = 1'b1;
              nxt_q.rx = {q_ff.rx[6:0], spi_miso};
            end
            default: begin
              nxt_q.sclk = 1'b0;
              nxt_q.ph = 2'h0;
              nxt_q.sh = {q_ff.sh[7:0], 1'b0};
              nxt_q.bitn = q_ff.bitn + 4'h1;
              if (q_ff.bitn == 4'h7) begin
                nxt_q.done = 1'b1;
                nxt_q.st = E_IDLE;
              end
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q_ff <= '{st: E_IDLE, default: '0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign e.done = q_ff.done;
  assign e.nack = q_ff.nack;
  assign e.rx = q_ff.rx;
  assign scl_oe = q_ff.scl_oe;
  assign sda_oe = q_ff.sda_oe;
  assign spi_sclk = q_ff.sclk;
  assign spi_mosi = q_ff.mosi;

  a_engine_done_bound: assert property (@(posedge sys_clk) disable iff (!reset_n)
    e.go && q_ff.st == E_IDLE |-> ##[1:1000] e.done) else $error("engine op did not finish");

endmodule : usbcb_engine

// file: src/usbcb_bridge.sv
`timescale 1ns/1ps
`include "usbcb_cfg.svh"
// Summary of operation
// - Device presents a vendor-specific class code with report-shaped packets.
// - Byte 0 ORs operation (0x00 read, 0x10 write) with interface selector.
// - Selector: 0x08 pins, 0x04 SPI16, 0x02 fast I2C, 0x01 I2C, 0x00 SPI8.
// - Byte 1 is I2C target address, or SPI16 register address high byte.
// - Byte 2 is the number of data bytes to transfer.
// - Byte 3 is register address, or SPI16 register address low byte.
// - Write data from byte 4, at most 60 bytes per command.
// - Every command gets a reply whose byte 0 is interface byte OR status.
// - Success sets done flag 0x20 in reply byte 0.
// - Serial failure such as missing I2C acknowledge sets flag 0x40.
// - Undefined byte 0 is rejected with request error flag 0x80.
// - Reply bytes 1 and 3 echo for I2C, carry shifted-in data for SPI16; SPI8 echoes byte 1, shifts into byte 3.
// - Reply repeats length in byte 2 and echoes data bytes 4 to 60.
// - Read carries bytes 0-3; reply returns read bytes from byte 4.
// - Pin command uses one byte, bits 0-6 are pins, addresses ignored.
module usbcb_bridge
  import usbcb_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic CMD_VALID,
  input wire logic [7:0] CMD_DATA,
  input wire logic CMD_LAST,
  output logic CMD_READY,
  output logic REPLY_VALID,
  output logic [7:0] REPLY_DATA,
  output logic REPLY_LAST,
  input wire logic REPLY_READY,
  output logic [7:0] IFACE_CLASS,
  output logic BUSY,
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic SPI_SCLK,
  output logic SPI_MOSI,
  input wire logic SPI_MISO,
  output logic SPI_CS_N,
  input wire logic [6:0] GPIO_IN,
  output logic [6:0] GPIO_OUT,
  output logic [6:0] GPIO_OE
);

  typedef struct packed {
    usbcb_state_type st;
    logic [6:0] wr_cnt;
    logic [6:0] rlen;
    logic [5:0] idx;
    logic [5:0] left;
    logic [7:0] status;
    logic busy;
    logic go;
    usbcb_ecmd_type ecmd;
    logic [7:0] tx;
    logic last;
    logic write;
    logic i2c;
    logic spi16;
    logic fast;
    logic cs_n;
    logic rvalid;
    logic [7:0] rdata;
    logic rlast;
    logic [6:0] gpio_out;
    logic [6:0] gpio_oe;
  } usbcb_top_state_type;

  usbcb_top_state_type q_ff, nxt_q;
  logic [7:0] mem [0:63];
  logic mem_we;
  logic [5:0] mem_wa;
  logic [7:0] mem_wd;
  logic [7:0] b0;
  logic [3:0] sel;
  logic legal;
  logic [7:0] len;
  logic [5:0] data_a;
  logic [7:0] stat_fin;
  logic [6:0] want;

  usbcb_eng_if eif ();

  usbcb_engine u_engine (
    .sys_clk(SYS_CLK),
    .reset_n(RESET_N),
    .e(eif.eng),
    .scl_in(SCL_IN),
    .scl_oe(SCL_OE),
    .sda_in(SDA_IN),
    .sda_oe(SDA_OE),
    .spi_sclk(SPI_SCLK),
    .spi_mosi(SPI_MOSI),
    .spi_miso(SPI_MISO)
  );

  assign eif.go = q_ff.go;
  assign eif.cmd = q_ff.ecmd;
  assign eif.fast = q_ff.fast;
  assign eif.last = q_ff.last;
  assign eif.tx = q_ff.tx;

  always_comb begin
    b0 = mem[`USBCB_B_IFACE];
    sel = 4'(b0 & `USBCB_SEL_MASK);
    legal = ((b0 & `USBCB_BAD_MASK) == 8'h00) && (sel == `USBCB_SEL_SPI8 || sel == `USBCB_SEL_TWO_WIRE_STANDARD_MODE ||
      sel == `USBCB_SEL_I2C_FAST || sel == `USBCB_SEL_SPI16 || sel == `USBCB_SEL_GPIO);
    len = (mem[`USBCB_B_LEN] > `USBCB_DATA_MAX) ? `USBCB_DATA_MAX : mem[`USBCB_B_LEN];
    if (sel == `USBCB_SEL_GPIO) begin
      len = `USBCB_GPIO_LEN;
    end
    want = (((b0 & `USBCB_OP_WRITE) != 8'h00) || !legal) ? q_ff.wr_cnt : `USBCB_HDR_LEN + len[6:0];
    data_a = 6'(`USBCB_B_DATA + q_ff.idx);
    stat_fin = q_ff.status;
    if ((q_ff.status & (`USBCB_ST_REQ_ERR | `USBCB_ST_BUS_ERR)) == 8'h00) begin
      stat_fin = q_ff.status | `USBCB_ST_DONE;
    end
    nxt_q = q_ff;
    nxt_q.go = 1'b0;
    mem_we = 1'b0;
    mem_wa = q_ff.wr_cnt[5:0];
    mem_wd = CMD_DATA;
    case (q_ff.st)
      S_IDLE: begin
        if (CMD_VALID) begin
          // Bytes past the endpoint limit are dropped, not wrapped
          if (q_ff.wr_cnt < `USBCB_PKT_MAX) begin
            mem_we = 1'b1;
            nxt_q.wr_cnt = q_ff.wr_cnt + 7'h01;
          end
          if (CMD_LAST) begin
            nxt_q.st = S_DECODE;
          end
        end
      end
      S_DECODE: begin
        nxt_q.status = 8'h00;
        nxt_q.idx = 6'h00;
        nxt_q.left = len[5:0];
        nxt_q.write = (b0 & `USBCB_OP_WRITE) != 8'h00;
        nxt_q.i2c = (sel == `USBCB_SEL_TWO_WIRE_STANDARD_MODE) || (sel == `USBCB_SEL_I2C_FAST);
        nxt_q.fast = (sel == `USBCB_SEL_I2C_FAST);
        nxt_q.spi16 = (sel == `USBCB_SEL_SPI16);
        nxt_q.rlen = (want < `USBCB_HDR_LEN) ? `USBCB_HDR_LEN : (want > `USBCB_REPLY_MAX) ? `USBCB_REPLY_MAX : want;
        if (!legal || q_ff.wr_cnt < `USBCB_HDR_LEN) begin
          nxt_q.status = `USBCB_ST_REQ_ERR;
          nxt_q.st = S_REPLY;
        end else if (sel == `USBCB_SEL_GPIO) begin
          nxt_q.st = S_GPIO;
        end else if (nxt_q.i2c) begin
          nxt_q.st = S_START;
        end else begin
          nxt_q.cs_n = 1'b0;
          nxt_q.st = (sel == `USBCB_SEL_SPI16) ? S_REG_HI : S_REG;
        end
      end
      S_GPIO: begin
        if (q_ff.write) begin
          nxt_q.gpio_out = mem[`USBCB_B_DATA][6:0];
          nxt_q.gpio_oe = 7'h7f;
        end else begin
          mem_we = 1'b1;
          mem_wa = `USBCB_B_DATA;
          mem_wd = {1'b0, GPIO_IN};
        end
        nxt_q.st = S_REPLY;
      end
      S_START, S_RESTART: begin
        if (!q_ff.busy) begin
          nxt_q.go = 1'b1;
          nxt_q.busy = 1'b1;
          nxt_q.ecmd = ECMD_START;
        end else if (eif.done) begin
          nxt_q.busy = 1'b0;
          nxt_q.st = (q_ff.st == S_START) ? S_ADDR : S_ADDR_RD;
        end
      end
      S_ADDR, S_ADDR_RD: begin
        if (!q_ff.busy) begin
          nxt_q.go = 1'b1;
          nxt_q.busy = 1'b1;
          nxt_q.ecmd = ECMD_WRITE;
          nxt_q.tx = {mem[`USBCB_B_ADDR][7:1], q_ff.st == S_ADDR_RD};
        end else if (eif.done) begin
          nxt_q.busy = 1'b0;
          if (eif.nack) begin
            nxt_q.status = `USBCB_ST_BUS_ERR;
            nxt_q.st = S_STOP;
          end else begin
            nxt_q.st = (q_ff.st == S_ADDR) ? S_REG : S_DATA;
          end
        end
      end
      S_REG_HI, S_REG: begin
        if (!q_ff.busy) begin
          nxt_q.go = 1'b1;
          nxt_q.busy = 1'b1;
          nxt_q.ecmd = q_ff.i2c ? ECMD_WRITE : ECMD_SPI;
          nxt_q.tx = (q_ff.st == S_REG_HI) ? mem[`USBCB_B_ADDR] : mem[`USBCB_B_REG];
        end else if (eif.done) begin
          nxt_q.busy = 1'b0;
          if (!q_ff.i2c) begin
            mem_we = 1'b1;
            mem_wa = (q_ff.st == S_REG_HI) ? `USBCB_B_ADDR : `USBCB_B_REG;
            mem_wd = eif.rx;
          end
          if (q_ff.i2c && eif.nack) begin
            nxt_q.status = `USBCB_ST_BUS_ERR;
            nxt_q.st = S_STOP;
          end else if (q_ff.st == S_REG_HI) begin
            nxt_q.st = S_REG;
          end else begin
            nxt_q.st = (q_ff.i2c && !q_ff.write) ? S_RESTART : S_DATA;
          end
        end
      end
      S_DATA: begin
        if (q_ff.left == 6'h00 && !q_ff.busy) begin
          nxt_q.cs_n = 1'b1;
          nxt_q.idx = 6'h00;
          nxt_q.st = q_ff.i2c ? S_STOP : S_REPLY;
        end else if (!q_ff.busy) begin
          nxt_q.go = 1'b1;
          nxt_q.busy = 1'b1;
          nxt_q.ecmd = q_ff.i2c ? (q_ff.write ? ECMD_WRITE : ECMD_READ) : ECMD_SPI;
          nxt_q.tx = q_ff.write ? mem[data_a] : 8'h00;
          nxt_q.last = (q_ff.left == 6'h01);
        end else if (eif.done) begin
          nxt_q.busy = 1'b0;
          nxt_q.idx = q_ff.idx + 6'h01;
          nxt_q.left = q_ff.left - 6'h01;
          if (!q_ff.write) begin
            mem_we = 1'b1;
            mem_wa = data_a;
            mem_wd = eif.rx;
          end
          if (q_ff.i2c && q_ff.write && eif.nack) begin
            nxt_q.status = `USBCB_ST_BUS_ERR;
            nxt_q.st = S_STOP;
          end
        end
      end
      S_STOP: begin
        if (!q_ff.busy) begin
          nxt_q.go = 1'b1;
          nxt_q.busy = 1'b1;
          nxt_q.ecmd = ECMD_STOP;
        end else if (eif.done) begin
          nxt_q.busy = 1'b0;
          nxt_q.idx = 6'h00;
          nxt_q.st = S_REPLY;
        end
      end
      default: begin
        // One idle cycle per byte keeps the memory read simple
        if (!q_ff.rvalid) begin
          nxt_q.rvalid = 1'b1;
          nxt_q.rlast = ({1'b0, q_ff.idx} == q_ff.rlen - 7'h01);
          if (q_ff.idx == 6'h00) begin
            nxt_q.status = stat_fin;
            nxt_q.rdata = b0 | stat_fin;
          end else begin
            nxt_q.rdata = mem[q_ff.idx];
          end
        end else if (REPLY_READY) begin
          nxt_q.rvalid = 1'b0;
          nxt_q.idx = q_ff.idx + 6'h01;
          if (q_ff.rlast) begin
            nxt_q.wr_cnt = 7'h00;
            nxt_q.st = S_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      q_ff <= '{st: S_IDLE, ecmd: ECMD_START, cs_n: 1'b1, default: '0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign CMD_READY = (q_ff.st == S_IDLE);
  assign REPLY_VALID = q_ff.rvalid;
  assign REPLY_DATA = q_ff.rdata;
  assign REPLY_LAST = q_ff.rlast;
  assign IFACE_CLASS = `USBCB_VENDOR_CLASS;
  assign BUSY = (q_ff.st != S_IDLE);
  assign SCL_OUT = 1'b0;
  assign SDA_OUT = 1'b0;
  assign SPI_CS_N = q_ff.cs_n;
  assign GPIO_OUT = q_ff.gpio_out;
  assign GPIO_OE = q_ff.gpio_oe;

  a_req_error_flag: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    q_ff.st == S_DECODE && !legal |=> q_ff.st == S_REPLY && q_ff.status == `USBCB_ST_REQ_ERR)
    else $error("illegal byte 0 not rejected");
  a_done_exclusive: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    REPLY_VALID && q_ff.idx == 6'h00 |-> q_ff.status[5] == !(q_ff.status[7] || q_ff.status[6]) &&
    REPLY_DATA == (b0 | q_ff.status))
    else $error("done flag wrong");
  a_reply_byte0: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    REPLY_VALID && q_ff.idx == 6'h00 |-> (REPLY_DATA & 8'h1f) == (b0 & 8'h1f))
    else $error("reply byte 0 lost interface bits");
  a_nack_bus_err: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    q_ff.busy && eif.done && eif.nack && q_ff.i2c && q_ff.ecmd == ECMD_WRITE |=>
    q_ff.status[6] && q_ff.st == S_STOP) else $error("missing acknowledge not flagged");
  a_len_echo: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    REPLY_VALID && q_ff.idx == `USBCB_B_LEN |-> REPLY_DATA == mem[`USBCB_B_LEN])
    else $error("length not echoed");
  a_gpio_write: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    q_ff.st == S_GPIO && q_ff.write |=> GPIO_OUT == $past(mem[`USBCB_B_DATA][6:0]) && GPIO_OE == 7'h7f)
    else $error("pin write not applied");
  a_spi_cs_frame: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    q_ff.busy && q_ff.ecmd == ECMD_SPI |-> !SPI_CS_N) else $error("SPI shift outside select");
  a_reply_follows: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    q_ff.st == S_DECODE && !legal |-> ##[2:3] REPLY_VALID) else $error("no reply after reject");

endmodule : usbcb_bridge

// file: test/usbcb_i2c_tgt.sv
`timescale 1ns/1ps
module usbcb_i2c_tgt #(
  parameter logic [6:0] ADDR = 7'h50
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe
);
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [7:0] tx;
  logic [7:0] ptr;
  logic act;
  logic rd;
  logic nak;
  int bn;
  int idx;
  initial begin
    sda_oe = 1'b0;
    act = 1'b0;
  end
  // Repeated start keeps the pointer for the read phase
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1'b1;
    rd = 1'b0;
    // The start's own scl fall is not a bit
    bn = -1;
    idx = 0;
  end
  always @(posedge sda) if (scl === 1'b1) act = 1'b0;
  always @(posedge scl) if (act) begin
    if (bn < 8) sh = {sh[6:0], sda};
    else nak = sda;
  end
  // Changes only after scl falls, never while scl is high
  always @(negedge scl) if (act) begin
    if (bn < 7) begin
      bn++;
      if (rd && idx > 0) sda_oe = ~tx[7 - bn];
    end else if (bn == 7) begin
      bn = 8;
      sda_oe = 1'b0;
      if (!rd || idx == 0) begin
        if (idx == 0) begin
          sda_oe = (sh[7:1] == ADDR);
          rd = sh[0];
          act = sda_oe;
        end else if (idx == 1) begin
          ptr = sh;
          sda_oe = 1'b1;
        end else begin
          mem[ptr] = sh;
          ptr++;
          sda_oe = 1'b1;
        end
      end
    end else begin
      bn = 0;
      idx++;
      sda_oe = 1'b0;
      if (rd) begin
        if (nak === 1'b1) act = 1'b0;
        else begin
          tx = mem[ptr];
          ptr++;
          sda_oe = ~tx[7];
        end
      end
    end
  end
endmodule : usbcb_i2c_tgt

// file: test/usbcb_bridge_tb_top.sv
`timescale 1ns/1ps
module usbcb_bridge_tb_top;
  logic SYS_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic CMD_VALID = 1'b0;
  logic CMD_LAST = 1'b0;
  logic REPLY_READY = 1'b0;
  logic miso_bit = 1'b0;
  logic [7:0] CMD_DATA = 8'h00;
  logic [6:0] GPIO_IN = 7'h00;
  logic CMD_READY, REPLY_VALID, REPLY_LAST, BUSY, SCL_OE, SDA_OE, SPI_CS_N, tgt_oe;
  logic [7:0] REPLY_DATA, IFACE_CLASS;
  logic [6:0] GPIO_OUT, GPIO_OE;
  logic spi_sclk, spi_mosi, scl_out, sda_out;
  logic [7:0] msh;
  int mbits = 0;
  logic [7:0] mem [256];
  logic [7:0] cq[$], rq[$], eq[$], mq[$], xq[$];
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  wire logic scl = ~SCL_OE;
  wire logic sda = ~(SDA_OE | tgt_oe);
  // Idle MISO toggles so a stale level never passes for data
  wire logic miso = SPI_CS_N ? cyc[0] : miso_bit;

  usbcb_bridge dut_u (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .CMD_VALID(CMD_VALID), .CMD_DATA(CMD_DATA),
    .CMD_LAST(CMD_LAST), .CMD_READY(CMD_READY), .REPLY_VALID(REPLY_VALID), .REPLY_DATA(REPLY_DATA),
    .REPLY_LAST(REPLY_LAST), .REPLY_READY(REPLY_READY), .IFACE_CLASS(IFACE_CLASS), .BUSY(BUSY),
    .SCL_IN(scl), .SCL_OUT(scl_out), .SCL_OE(SCL_OE), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(SDA_OE),
    .SPI_SCLK(spi_sclk), .SPI_MOSI(spi_mosi), .SPI_MISO(miso), .SPI_CS_N(SPI_CS_N), .GPIO_IN(GPIO_IN),
    .GPIO_OUT(GPIO_OUT), .GPIO_OE(GPIO_OE));
  usbcb_i2c_tgt #(.ADDR(7'h50)) tgt_u (.scl(scl), .sda(sda), .sda_oe(tgt_oe));

  always #50 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 100000) begin
      fail_count++;
      finish_test();
    end
  end
  // Mode 0 target side: MOSI is taken on the rising clock
  always @(posedge spi_sclk) begin
    msh = {msh[6:0], spi_mosi};
    mbits++;
    if (mbits % 8 == 0) mq.push_back(msh);
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Outputs are looked at on the falling edge, where they are settled
  task automatic xfer();
    rq = {};
    mq = {};
    foreach (cq[i]) begin
      @(negedge SYS_CLK);
      CMD_VALID = 1'b1;
      CMD_DATA = cq[i];
      CMD_LAST = (i == cq.size() - 1);
      while (CMD_READY !== 1'b1) @(negedge SYS_CLK);
    end
    @(negedge SYS_CLK);
    CMD_VALID = 1'b0;
    CMD_LAST = 1'b0;
    chk("ready", 8'h00, {7'h00, CMD_READY});
    chk("busy", 8'h01, {7'h00, BUSY});
    chk("pin out levels", 8'h00, {6'h00, scl_out, sda_out});
    do begin
      @(negedge SYS_CLK);
      REPLY_READY = 1'($urandom_range(1));
      if (REPLY_VALID === 1'b1 && REPLY_READY) rq.push_back(REPLY_DATA);
    end while (!(REPLY_VALID === 1'b1 && REPLY_READY && REPLY_LAST === 1'b1));
  endtask : xfer

  task automatic cmd(input logic [7:0] b0, b1, n, b3, st, input int nd);
    logic [7:0] f;
    f = {8{miso_bit}};
    cq = {b0, b1, n, b3};
    repeat (nd) cq.push_back(8'($urandom));
    eq = cq;
    eq[0] = b0 | st;
    xq = {};
    if (st == 8'h20) begin
      if (b0[3:0] == 4'h4) eq[1] = f;
      if (b0[3:0] == 4'h4) xq.push_back(b1);
      if (b0[3:0] == 4'h4 || b0[3:0] == 4'h0) eq[3] = f;
      if (b0[3:0] == 4'h4 || b0[3:0] == 4'h0) xq.push_back(b3);
      for (int a = 0; a < n; a++) begin
        // SPI reads clock out zeros
        if (b0[3:0] inside {4'h0, 4'h4}) xq.push_back(b0[4] ? cq[4 + a] : 8'h00);
        if (b0[4] && b0[3:0] inside {4'h1, 4'h2}) mem[8'(b3 + a)] = cq[4 + a];
        else if (!b0[4] && b0[3:0] inside {4'h1, 4'h2}) eq.push_back(mem[8'(b3 + a)]);
        else if (!b0[4] && b0[3:0] == 4'h8) eq.push_back({1'b0, GPIO_IN});
        else if (!b0[4]) eq.push_back(f);
      end
    end
    while (eq.size() > 61) void'(eq.pop_back());
    xfer();
    chk("reply length", 8'(eq.size()), 8'(rq.size()));
    foreach (eq[i]) chk($sformatf("reply byte %0d", i), eq[i], rq[i]);
    chk("spi byte count", 8'(xq.size()), 8'(mq.size()));
    foreach (xq[i]) chk($sformatf("spi byte %0d", i), xq[i], mq[i]);
  endtask : cmd

  task automatic finish_test();
    $display("checks_done %0d fail_count %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    logic [7:0] r;
    logic [7:0] bad [4] = '{8'h13, 8'h03, 8'h1c, 8'h48};
    void'($urandom(21));
    GPIO_IN = 7'($urandom);
    r = 8'($urandom_range(180));
    repeat (10) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    RESET_N = 1'b1;
    chk("class", 8'hff, IFACE_CLASS);
    foreach (bad[i]) cmd(bad[i], 8'ha0, 8'h02, 8'h05, 8'h80, 2);
    cmd(8'h11, 8'ha0, 8'h02, 8'h05, 8'h20, 2);
    cmd(8'h02, 8'ha0, 8'h02, 8'h05, 8'h20, 0);
    cmd(8'h12, 8'ha0, 8'h04, r, 8'h20, 4);
    cmd(8'h01, 8'ha0, 8'h04, r, 8'h20, 0);
    cmd(8'h11, 8'h52, 8'h01, 8'h05, 8'h40, 1);
    cmd(8'h18, 8'h00, 8'h01, 8'h00, 8'h20, 1);
    chk("pins out", {1'b0, cq[4][6:0]}, {1'b0, GPIO_OUT});
    chk("pins enable", 8'h7f, {1'b0, GPIO_OE});
    cmd(8'h08, 8'h00, 8'h01, 8'h00, 8'h20, 0);
    for (int k = 0; k < 2; k++) begin
      miso_bit = k[0];
      cmd(8'h10, 8'ha0, 8'h02, 8'h05, 8'h20, 2);
      cmd(8'h14, 8'h10, 8'h02, 8'he0, 8'h20, 2);
      cmd(8'h04, 8'h10, 8'h02, 8'he0, 8'h20, 0);
      cmd(8'h00, 8'ha0, 8'h03, 8'h05, 8'h20, 0);
    end
    cmd(8'h12, 8'ha0, 8'h3c, r, 8'h20, 60);
    cmd(8'h02, 8'ha0, 8'h03, r, 8'h20, 0);
    finish_test();
  end
endmodule : usbcb_bridge_tb_top
